// File: rtl/sooc_pkg.sv
// Constants, types and field layout for the supply on/off and margin control
// Notes on behaviour
// - All-pages 00h/01h/02h: immediate off, both/A/B
// - 80h/81h/82h on; 40h/41h/42h soft-off, per group
// - Readback gives standard byte, never group forms
// - 94h/98h margin low, ignore/act on faults
// - A4h/A8h margin high, ignore/act, supply on
// - Margin waits until enabled supplies are good
// - Command disabled: on/off bytes do nothing
// - Command disabled: margin only on enabled supplies
// - Command disabled, all pages: margin both groups
// - One config byte for both pins; 7:6 zero
// - Bit 5 clear: command AND pin
// - Bit 5 set: command OR pin
// - Bit 4 clear: supplies on regardless
// - Bit 4 set: enabled pin and/or command
// - Bit 3 enables command, bit 2 enables pin
// - Bit 1 selects pin polarity for on
// - Bit 0 clear: pin off uses soft-off
// - Bit 0 set: pin off is immediate
// - Both enabled, AND: either one turns off
// - Fault-ignoring margin masks that supply's faults
// - Undefined command byte sets fault flag, alert
// - Single page 0-11 affects that supply only
package sooc_pkg;

    localparam int          SOOC_NSUP          = 12;
    localparam logic [7:0]  SOOC_CMD_OPERATION = 8'h01;
    localparam logic [7:0]  SOOC_CMD_ON_OFF_CFG = 8'h02;
    localparam logic [7:0]  SOOC_PAGE_ALL      = 8'hFF;
    localparam logic [7:0]  SOOC_PAGE_MAX      = 8'h0B;

    // Supply command byte values
    localparam logic [7:0]  SOOC_OP_OFF_ALL    = 8'h00;
    localparam logic [7:0]  SOOC_OP_OFF_A      = 8'h01;
    localparam logic [7:0]  SOOC_OP_OFF_B      = 8'h02;
    localparam logic [7:0]  SOOC_OP_SOFT_ALL   = 8'h40;
    localparam logic [7:0]  SOOC_OP_SOFT_A     = 8'h41;
    localparam logic [7:0]  SOOC_OP_SOFT_B     = 8'h42;
    localparam logic [7:0]  SOOC_OP_ON_ALL     = 8'h80;
    localparam logic [7:0]  SOOC_OP_ON_A       = 8'h81;
    localparam logic [7:0]  SOOC_OP_ON_B       = 8'h82;
    localparam logic [7:0]  SOOC_OP_MLOW_IGN   = 8'h94;
    localparam logic [7:0]  SOOC_OP_MLOW_ACT   = 8'h98;
    localparam logic [7:0]  SOOC_OP_MHIGH_IGN  = 8'hA4;
    localparam logic [7:0]  SOOC_OP_MHIGH_ACT  = 8'hA8;

    // Policy config field positions
    localparam int          SOOC_CFG_OR        = 5;
    localparam int          SOOC_CFG_USE_CTL   = 4;
    localparam int          SOOC_CFG_CMD_EN    = 3;
    localparam int          SOOC_CFG_PIN_EN    = 2;
    localparam int          SOOC_CFG_POL       = 1;
    localparam int          SOOC_CFG_PIN_FAST  = 0;
    localparam logic [7:0]  SOOC_CFG_WMASK     = 8'h3F;

    // Values after reset
    localparam logic [7:0]  SOOC_OP_RST        = 8'h00;
    localparam logic [7:0]  SOOC_CFG_RST       = 8'h1E;

    typedef enum logic [2:0] {
        SOOC_MRG_OFF      = 3'h0,
        SOOC_MRG_LOW_IGN  = 3'h1,
        SOOC_MRG_LOW_ACT  = 3'h2,
        SOOC_MRG_HIGH_IGN = 3'h3,
        SOOC_MRG_HIGH_ACT = 3'h4
    } sooc_margin_t;

    typedef enum logic [1:0] {
        SOOC_ST_IDLE = 2'b01,
        SOOC_ST_EXEC = 2'b10
    } sooc_state_t;

    // One command transfer from the bus engine
    typedef struct packed {
        logic       rd;
        logic [7:0] page;
        logic [7:0] code;
        logic [7:0] data;
    } sooc_req_t;

endpackage

// File: rtl/sooc_ctrl.sv
// Supply on/off and margin command interpreter with link-side handshake
`timescale 1ns/100ps
module sooc_ctrl (
    input  wire logic                          clk_sys,
    input  wire logic                          rst_b,
    input  wire logic                          ce,
    input  wire logic                          link_clk,
    input  wire logic                          link_rst_b,
    input  wire logic                          link_wr_stb,
    input  wire sooc_pkg::sooc_req_t           link_req,
    output logic                               link_busy,
    output logic [7:0]                         link_rd_data,
    output logic                               link_rd_valid,
    input  wire logic                          control_input_pin_zero,
    input  wire logic                          control_input_pin_one,
    input  wire logic [11:0]                   group_b_member,
    input  wire logic [11:0]                   power_good,
    input  wire logic                          comm_fault_clear,
    output logic [11:0]                        supply_on,
    output logic [11:0]                        supply_fast_off,
    output sooc_pkg::sooc_margin_t [11:0]      margin_state,
    output logic [11:0]                        fault_ignore,
    output logic                               comm_fault_flag,
    output logic                               alert
);
    import sooc_pkg::*;

    // Group select carried by the low bits of a group-form byte
    function automatic logic [1:0] grp_sel(input logic [7:0] op);
        case (op[1:0])
            2'h1:    grp_sel = 2'b01;
            2'h2:    grp_sel = 2'b10;
            default: grp_sel = 2'b11;
        endcase
    endfunction

    // Byte legality depends on whether all pages are addressed
    function automatic logic op_valid(input logic [7:0] op,
                                      input logic       all_pg);
        case (op)
            SOOC_OP_OFF_ALL, SOOC_OP_SOFT_ALL, SOOC_OP_ON_ALL,
            SOOC_OP_MLOW_IGN, SOOC_OP_MLOW_ACT,
            SOOC_OP_MHIGH_IGN, SOOC_OP_MHIGH_ACT: op_valid = 1'b1;
            SOOC_OP_OFF_A, SOOC_OP_OFF_B, SOOC_OP_SOFT_A, SOOC_OP_SOFT_B,
            SOOC_OP_ON_A, SOOC_OP_ON_B:           op_valid = all_pg;
            default:                              op_valid = 1'b0;
        endcase
    endfunction

    // Margin selection carried by an on or margin byte
    function automatic sooc_margin_t margin_of(input logic [7:0] op);
        case (op)
            SOOC_OP_MLOW_IGN:  margin_of = SOOC_MRG_LOW_IGN;
            SOOC_OP_MLOW_ACT:  margin_of = SOOC_MRG_LOW_ACT;
            SOOC_OP_MHIGH_IGN: margin_of = SOOC_MRG_HIGH_IGN;
            SOOC_OP_MHIGH_ACT: margin_of = SOOC_MRG_HIGH_ACT;
            default:           margin_of = SOOC_MRG_OFF;
        endcase
    endfunction

    // Link clock domain; the ack toggle and answer come from system side
    sooc_req_t   hold_r;
    logic        req_tgl_r;
    logic        ack_tgl_r;
    logic [7:0]  rsp_r;
    logic        ack_s1_r;
    logic        ack_s2_r;
    logic        ack_s3_r;
    logic        busy_r;
    logic [7:0]  rd_data_r;
    logic        rd_valid_r;

    // Ack toggle from the system side, two stages then an edge stage
    always_ff @(posedge link_clk) begin
        if (!link_rst_b) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
        end
    end

    // Capture one transfer; held stable until the system side acks it
    always_ff @(posedge link_clk) begin
        if (!link_rst_b) begin
            hold_r     <= '0;
            req_tgl_r  <= 1'b0;
            busy_r     <= 1'b0;
            rd_data_r  <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= 1'b0;
            if (link_wr_stb && !busy_r) begin
                hold_r    <= link_req;
                req_tgl_r <= ~req_tgl_r;
                busy_r    <= 1'b1;
            end else if (busy_r && (ack_s2_r != ack_s3_r)) begin
                busy_r <= 1'b0;
                if (hold_r.rd) begin
                    rd_data_r  <= rsp_r;    // Stable since the ack toggled
                    rd_valid_r <= 1'b1;
                end
            end
        end
    end

    assign link_busy     = busy_r;
    assign link_rd_data  = rd_data_r;
    assign link_rd_valid = rd_valid_r;

    // System clock domain
    logic        req_s1_r;
    logic        req_s2_r;
    logic        req_s3_r;
    logic        pin0_s1_r;
    logic        pin0_s2_r;
    logic        pin1_s1_r;
    logic        pin1_s2_r;
    sooc_state_t state_r;
    sooc_req_t   req_r;
    logic [7:0]  op_rd_r;
    logic [7:0]  cfg_r;
    logic [11:0] cmd_on_r;
    logic [11:0] cmd_fast_r;
    sooc_margin_t [11:0] mrg_sel_r;
    logic [11:0] sup_on_r;
    logic [11:0] sup_fast_r;
    sooc_margin_t [11:0] mrg_out_r;
    logic [11:0] fign_r;
    logic        fault_r;
    logic        alert_r;

    // Request toggle crosses two flops then an edge stage; control pins cross through two flops each
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            req_s1_r  <= 1'b0;
            req_s2_r  <= 1'b0;
            req_s3_r  <= 1'b0;
            pin0_s1_r <= 1'b0;
            pin0_s2_r <= 1'b0;
            pin1_s1_r <= 1'b0;
            pin1_s2_r <= 1'b0;
        end else if (ce) begin
            req_s1_r  <= req_tgl_r;
            req_s2_r  <= req_s1_r;
            req_s3_r  <= req_s2_r;
            pin0_s1_r <= control_input_pin_zero;
            pin0_s2_r <= pin0_s1_r;
            pin1_s1_r <= control_input_pin_one;
            pin1_s2_r <= pin1_s1_r;
        end
    end

    // Transfer sequencer: take the held word, then execute and ack
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_r   <= SOOC_ST_IDLE;
            req_r     <= '0;
            ack_tgl_r <= 1'b0;
            rsp_r     <= 8'h00;
        end else if (ce) begin
            case (state_r)
                SOOC_ST_IDLE: begin
                    if (req_s2_r != req_s3_r) begin
                        req_r   <= hold_r;
                        state_r <= SOOC_ST_EXEC;
                    end
                end
                SOOC_ST_EXEC: begin
                    if (req_r.code == SOOC_CMD_ON_OFF_CFG) begin
                        rsp_r <= cfg_r;
                    end else if (req_r.code == SOOC_CMD_OPERATION) begin
                        rsp_r <= op_rd_r;
                    end else begin
                        rsp_r <= 8'h00;
                    end
                    ack_tgl_r <= ~ack_tgl_r;
                    state_r   <= SOOC_ST_IDLE;
                end
                default: state_r <= SOOC_ST_IDLE;
            endcase
        end
    end

    // Decode of the transfer being executed
    logic        exec;
    logic        all_pg;
    logic        wr_op;
    logic        wr_cfg;
    logic        op_ok;
    logic        is_onoff;
    logic        is_on;
    logic        cmd_en;
    logic [11:0] tgt;
    logic [11:0] in_grp;
    logic [1:0]  gsel;

    always_comb begin
        exec     = (state_r == SOOC_ST_EXEC) && !req_r.rd;
        all_pg   = (req_r.page == SOOC_PAGE_ALL);
        wr_op    = exec && (req_r.code == SOOC_CMD_OPERATION);
        wr_cfg   = exec && (req_r.code == SOOC_CMD_ON_OFF_CFG);
        op_ok    = op_valid(req_r.data, all_pg);
        is_on    = req_r.data[7];
        is_onoff = !req_r.data[7] || (req_r.data[6:0] == 7'h00)
                   || (req_r.data[7:2] == 6'h20);
        cmd_en   = cfg_r[SOOC_CFG_CMD_EN];
        gsel     = grp_sel(req_r.data);
        if (all_pg) begin
            tgt = in_grp;
        end else if (req_r.page <= SOOC_PAGE_MAX) begin
            tgt = 12'h001 << req_r.page[3:0];
        end else begin
            tgt = 12'h000;
        end
    end

    // Membership of each supply in the addressed groups
    genvar gi;
    generate
        for (gi = 0; gi < SOOC_NSUP; gi++) begin : g_grp
            assign in_grp[gi] = group_b_member[gi] ? gsel[1] : gsel[0];
        end
    endgenerate

    // Standard-form readback of the command byte
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            op_rd_r <= SOOC_OP_RST;
        end else if (ce && wr_op && op_ok) begin
            if (is_onoff) begin
                op_rd_r <= {req_r.data[7:2], 2'b00};
            end else begin
                op_rd_r <= req_r.data;
            end
        end
    end

    // Policy config; one byte serves both pins, top bits held at zero
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cfg_r <= SOOC_CFG_RST;
        end else if (ce && wr_cfg) begin
            cfg_r <= req_r.data & SOOC_CFG_WMASK;
        end
    end

    // Command on/off state per supply; ignored while disabled
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cmd_on_r   <= 12'h000;
            cmd_fast_r <= 12'h000;
        end else if (ce && wr_op && op_ok && cmd_en) begin
            for (int i = 0; i < SOOC_NSUP; i++) begin
                if (tgt[i]) begin
                    cmd_on_r[i] <= is_on;
                    cmd_fast_r[i] <= (req_r.data[7:6] == 2'b00);
                end
            end
        end
    end

    // Margin selection; without command enable only running supplies
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mrg_sel_r <= {SOOC_NSUP{SOOC_MRG_OFF}};
        end else if (ce && wr_op && op_ok && is_on) begin
            for (int i = 0; i < SOOC_NSUP; i++) begin
                if (tgt[i] && (cmd_en || sup_on_r[i])) begin
                    mrg_sel_r[i] <= margin_of(req_r.data);
                end
            end
        end
    end

    // Combined on request per supply, recomputed every cycle
    logic [11:0] pin_on;
    logic [11:0] want_on;
    logic [11:0] want_fast;
    logic        pg_all;

    generate
        for (gi = 0; gi < SOOC_NSUP; gi++) begin : g_comb
            logic pin_lvl;
            logic c_on;
            assign pin_lvl = group_b_member[gi] ? pin1_s2_r : pin0_s2_r;
            // Polarity picks which pin level asks for on
            assign pin_on[gi] = cfg_r[SOOC_CFG_POL] ? pin_lvl
                                                    : ~pin_lvl;
            assign c_on = cmd_on_r[gi];
            always_comb begin
                if (!cfg_r[SOOC_CFG_USE_CTL]) begin
                    want_on[gi] = 1'b1;
                end else if (cfg_r[SOOC_CFG_CMD_EN]
                             && cfg_r[SOOC_CFG_PIN_EN]) begin
                    if (cfg_r[SOOC_CFG_OR]) begin
                        want_on[gi] = c_on | pin_on[gi];
                    end else begin
                        want_on[gi] = c_on & pin_on[gi];
                    end
                end else if (cfg_r[SOOC_CFG_CMD_EN]) begin
                    want_on[gi] = c_on;
                end else if (cfg_r[SOOC_CFG_PIN_EN]) begin
                    want_on[gi] = pin_on[gi];
                end else begin
                    want_on[gi] = 1'b0;
                end
                // Off is immediate when the source that dropped asks so
                want_fast[gi] = !want_on[gi] && (
                    (cfg_r[SOOC_CFG_CMD_EN] && !c_on && cmd_fast_r[gi])
                    || (cfg_r[SOOC_CFG_PIN_EN] && !pin_on[gi]
                        && cfg_r[SOOC_CFG_PIN_FAST]));
            end
        end
    endgenerate

    // Margining holds off until every running supply is good
    assign pg_all = &(power_good | ~sup_on_r);

    // Registered supply outputs follow the request with no latency games
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sup_on_r   <= 12'h000;
            sup_fast_r <= 12'h000;
        end else if (ce) begin
            sup_on_r   <= want_on;
            sup_fast_r <= want_fast;
        end
    end

    // Applied margin and fault masking per supply
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mrg_out_r <= {SOOC_NSUP{SOOC_MRG_OFF}};
            fign_r    <= 12'h000;
        end else if (ce) begin
            for (int i = 0; i < SOOC_NSUP; i++) begin
                if (sup_on_r[i] && want_on[i] && pg_all) begin
                    mrg_out_r[i] <= mrg_sel_r[i];
                    fign_r[i] <= (mrg_sel_r[i] == SOOC_MRG_LOW_IGN)
                        || (mrg_sel_r[i] == SOOC_MRG_HIGH_IGN);
                end else begin
                    mrg_out_r[i] <= SOOC_MRG_OFF;
                    fign_r[i]    <= 1'b0;
                end
            end
        end
    end

    // Invalid byte flag; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            fault_r <= 1'b0;
            alert_r <= 1'b0;
        end else if (ce) begin
            if (wr_op && !op_ok) begin
                fault_r <= 1'b1;
                alert_r <= 1'b1;
            end else if (comm_fault_clear) begin
                fault_r <= 1'b0;
                alert_r <= 1'b0;
            end
        end
    end

    assign supply_on       = sup_on_r;
    assign supply_fast_off = sup_fast_r;
    assign margin_state    = mrg_out_r;
    assign fault_ignore    = fign_r;
    assign comm_fault_flag = fault_r;
    assign alert           = alert_r;

endmodule

// File: test/sooc_chk.sv
// Port-level assertions for the supply on/off and margin controller
`timescale 1ns/100ps
module sooc_chk (
    input wire logic                     clk_sys,
    input wire logic                     rst_b,
    input wire logic                     ce,
    input wire logic                     link_clk,
    input wire logic                     link_rst_b,
    input wire logic                     link_wr_stb,
    input wire logic                     link_busy,
    input wire logic                     link_rd_valid,
    input wire logic [11:0]              power_good,
    input wire logic                     comm_fault_clear,
    input wire logic [11:0]              supply_on,
    input wire logic [11:0]              supply_fast_off,
    input wire sooc_pkg::sooc_margin_t [11:0] margin_state,
    input wire logic [11:0]              fault_ignore,
    input wire logic                     comm_fault_flag,
    input wire logic                     alert
);
    import sooc_pkg::*;
    logic [11:0] mrg_act, mrg_ign, pg_ok;
    // Per-supply view of the margin bus so each check stays vector-wide
    always_comb begin
        pg_ok = power_good | ~supply_on;
        for (int i = 0; i < 12; i++) begin
            mrg_act[i] = margin_state[i] != SOOC_MRG_OFF;
            mrg_ign[i] = margin_state[i] == SOOC_MRG_LOW_IGN ||
                         margin_state[i] == SOOC_MRG_HIGH_IGN;
        end
    end
    property p_alert_mirror;
        @(posedge clk_sys) disable iff (!rst_b) alert == comm_fault_flag;
    endproperty
    a_alert_mirror: assert property (p_alert_mirror)
        else $error("alert differs from fault flag");
    property p_flag_sticky; @(posedge clk_sys) disable iff (!rst_b)
        comm_fault_flag && !comm_fault_clear |=> comm_fault_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("fault flag dropped without a clear");
    property p_fast_only_off; @(posedge clk_sys) disable iff (!rst_b)
        (supply_fast_off & supply_on) == 12'h000;
    endproperty
    a_fast_only_off: assert property (p_fast_only_off)
        else $error("fast off shown on a running supply");
    property p_margin_on; @(posedge clk_sys) disable iff (!rst_b)
        (mrg_act & ~$past(supply_on)) == 12'h000;
    endproperty
    a_margin_on: assert property (p_margin_on)
        else $error("margin applied to a supply that is off");
    property p_margin_pg; @(posedge clk_sys) disable iff (!rst_b)
        mrg_act != 12'h000 && $past(ce) |-> $past(pg_ok) == 12'hFFF;
    endproperty
    a_margin_pg: assert property (p_margin_pg)
        else $error("margin while a running supply is not good");
    property p_ignore_match; @(posedge clk_sys) disable iff (!rst_b)
        fault_ignore == mrg_ign;
    endproperty
    a_ignore_match: assert property (p_ignore_match)
        else $error("fault ignore does not follow margin state");
    property p_rdv_fall; @(posedge link_clk) disable iff (!link_rst_b)
        link_rd_valid |-> !link_busy && $past(link_busy);
    endproperty
    a_rdv_fall: assert property (p_rdv_fall)
        else $error("read answer not at the end of busy");
    property p_busy_bound; @(posedge link_clk) disable iff (!link_rst_b)
        link_wr_stb && !link_busy |=> link_busy ##[1:16] !link_busy;
    endproperty
    a_busy_bound: assert property (p_busy_bound)
        else $error("command not taken or not answered in time");
endmodule

bind sooc_ctrl sooc_chk u_chk (
    .clk_sys, .rst_b, .ce, .link_clk, .link_rst_b, .link_wr_stb,
    .link_busy, .link_rd_valid, .power_good, .comm_fault_clear,
    .supply_on, .supply_fast_off, .margin_state, .fault_ignore,
    .comm_fault_flag, .alert
);

// File: test/sooc_host.sv
// Host-side command master for the controller's link port
`timescale 1ns/100ps
module sooc_host (
    input  wire logic                link_clk,
    input  wire logic                link_busy,
    input  wire logic [7:0]          link_rd_data,
    input  wire logic                link_rd_valid,
    output sooc_pkg::sooc_req_t      link_req,
    output logic                     link_wr_stb
);
    import sooc_pkg::*;
    initial begin
        link_wr_stb = 1'b0;
        link_req = '0;
    end
    // One command at a time; gap lets the host be prompt or slow
    task automatic xfer(input sooc_req_t r, input int gap,
                        output logic [7:0] q, output logic v, ok);
        repeat (gap + 1) @(negedge link_clk);
        link_req = r;
        link_wr_stb = 1'b1;
        @(negedge link_clk);
        link_wr_stb = 1'b0;
        link_req = sooc_req_t'(~r); // Released lines never keep the word
        ok = 1'b0;
        for (int i = 0; i < 40; i++) begin
            if (!link_busy) begin
                ok = 1'b1;
                break;
            end
            @(negedge link_clk);
        end
        q = link_rd_data;
        v = link_rd_valid;
    endtask
endmodule

// File: test/sooc_ctrl_bench.sv
// Self-checking bench for the supply on/off and margin controller
`timescale 1ns/100ps
module sooc_ctrl_bench;
    import sooc_pkg::*;
    logic                clk_sys, link_clk, rst_b, ce, p0, p1, cfc;
    logic [11:0]         grp_b, pg, son, sfo, fign, keep;
    sooc_margin_t [11:0] ms;
    logic                flag, alert, stb, busy, rdv;
    logic [7:0]          rdd, lfsr;
    sooc_req_t           req;
    int                  err_count, checks_done, m_cfg, m_flag, m_op;
    int                  m_on[12], m_fast[12], m_sel[12];
    int tbl[13] = '{8'h00, 8'h01, 8'h02, 8'h40, 8'h41, 8'h42, 8'h80,
                    8'h81, 8'h82, 8'h94, 8'h98, 8'hA4, 8'hA8};
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Link clock offset so its edges never meet the system clock's
    initial begin
        link_clk = 1'b0;
        #7;
        forever #40 link_clk = ~link_clk;
    end
    sooc_ctrl dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .link_clk(link_clk),
        .link_rst_b(rst_b), .link_wr_stb(stb), .link_req(req),
        .link_busy(busy), .link_rd_data(rdd), .link_rd_valid(rdv),
        .control_input_pin_zero(p0), .control_input_pin_one(p1),
        .group_b_member(grp_b), .power_good(pg),
        .comm_fault_clear(cfc), .supply_on(son), .supply_fast_off(sfo),
        .margin_state(ms), .fault_ignore(fign),
        .comm_fault_flag(flag), .alert(alert)
    );
    sooc_host host (
        .link_clk(link_clk), .link_busy(busy), .link_rd_data(rdd),
        .link_rd_valid(rdv), .link_req(req), .link_wr_stb(stb)
    );
    function automatic logic [7:0] nxt(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic int pin_on(int i);
        logic lv = grp_b[i] ? p1 : p0;
        return m_cfg[1] ? lv : !lv;
    endfunction
    // Combined request; with bit 4 set, no pin and no command enabled means off
    function automatic int on_of(int i);
        int c = m_on[i];
        int p = pin_on(i);
        if (!m_cfg[4]) return 1;
        case (m_cfg[3:2])
            2'b11: return m_cfg[5] ? (c | p) : (c & p);
            2'b10: return c;
            2'b01: return p;
            default: return 0;
        endcase
    endfunction
    function automatic int legal(int g, int d);
        if (d inside {8'h00, 8'h40, 8'h80, 8'h94, 8'h98, 8'hA4, 8'hA8})
            return 1;
        return g == 8'hFF && d inside {8'h01, 8'h02, 8'h41, 8'h42,
                                       8'h81, 8'h82};
    endfunction
    function automatic int sel_of(int d);
        case (d)
            8'h94: return 1;
            8'h98: return 2;
            8'hA4: return 3;
            8'hA8: return 4;
            default: return 0;
        endcase
    endfunction
    task automatic chk(input logic [35:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Model outputs for every supply against the design's
    task automatic cmp_all;
        logic [11:0] eo, ef, ei;
        sooc_margin_t [11:0] em;
        int g = 1;
        for (int i = 0; i < 12; i++) begin
            eo[i] = on_of(i) != 0;
            if (eo[i] && !pg[i]) g = 0;
        end
        for (int i = 0; i < 12; i++) begin
            ef[i] = !eo[i] && ((m_cfg[3] && !m_on[i] && m_fast[i]) ||
                               (m_cfg[2] && !pin_on(i) && m_cfg[0]));
            em[i] = eo[i] && g ? sooc_margin_t'(m_sel[i]) : SOOC_MRG_OFF;
            ei[i] = em[i] inside {SOOC_MRG_LOW_IGN, SOOC_MRG_HIGH_IGN};
        end
        chk(son, eo);
        chk(sfo, ef);
        chk(ms, em);
        chk(fign, ei);
        chk({alert, flag}, {2{m_flag[0]}});
    endtask
    task automatic xf(input logic r, input int g, c, d,
                      output logic [7:0] q);
        logic v, ok;
        host.xfer({r, 8'(g), 8'(c), 8'(d)}, lfsr[1:0], q, v, ok);
        lfsr = nxt(lfsr);
        chk(ok, 1'b1);
        if (!ok) print_verdict();
        else chk(v, r);
    endtask
    task automatic rd(input int c, exp);
        logic [7:0] q;
        xf(1'b1, 8'hFF, c, 8'h00, q);
        chk(q, exp);
    endtask
    // Write, update the model, let outputs settle, then compare all
    task automatic wr(input int g, c, d);
        logic [7:0] q;
        int o;
        xf(1'b0, g, c, d, q);
        if (c == 2) m_cfg = d & 8'h3F;
        else if (c == 1 && !legal(g, d)) m_flag = 1;
        else if (c == 1) begin
            m_op = d & 8'hFC;
            for (int i = 0; i < 12; i++) begin
                if (g == 8'hFF ? d[1:0] == 0 || (d[1:0] == 2) == grp_b[i]
                               : g == i) begin
                    o = on_of(i);
                    if (m_cfg[3]) begin
                        m_on[i] = d[7];
                        m_fast[i] = d[7:6] == 0;
                    end
                    if (d[7] && (m_cfg[3] || o)) m_sel[i] = sel_of(d);
                end
            end
        end
        repeat (4) @(negedge clk_sys);
        cmp_all();
    endtask
    task automatic pins(input logic a, b);
        @(negedge clk_sys);
        p0 = a;
        p1 = b;
        repeat (5) @(negedge clk_sys);
        cmp_all();
    endtask
    // Main sequence
    initial begin
        {rst_b, cfc, ce, p0, p1} = 5'b00111;
        grp_b = 12'h0F0;
        pg = 12'hFFF;
        lfsr = 8'h35;
        m_cfg = 8'h1E;
        repeat (4) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (3) @(negedge clk_sys);
        cmp_all();
        rd(2, 8'h1E);
        rd(5, 8'h00);
        wr(8'hFF, 2, 8'hFF);
        rd(2, 8'h3F);
        wr(8'hFF, 2, 8'h18);
        grp_b = {lfsr, lfsr[3:0]};
        foreach (tbl[k]) begin
            wr(8'hFF, 1, 8'h80);
            wr(8'hFF, 1, tbl[k]);
            rd(1, m_op);
        end
        wr(8'hFF, 1, 8'h00);
        wr(5, 1, 8'hA4);
        pg[5] = 1'b0;
        repeat (3) @(negedge clk_sys);
        cmp_all();
        pg = 12'hFFF;
        wr(8'h0C, 1, 8'h80);
        wr(3, 1, 8'h81);
        wr(8'hFF, 1, 8'h55);
        cfc = 1'b1;
        @(negedge clk_sys);
        cfc = 1'b0;
        m_flag = 0;
        pins(1'b1, 1'b1);
        wr(8'hFF, 2, 8'h16);
        wr(8'hFF, 1, 8'h00);
        wr(8'hFF, 1, 8'h98);
        pins(1'b1, 1'b0);
        for (int k = 0; k < 24; k++) begin
            wr(8'hFF, 2, 8'h18);
            wr(8'hFF, 1, 8'h00);
            wr(8'hFF, 2, lfsr & 8'h3F);
            wr(8'hFF, 1, tbl[lfsr % 13]);
            pg = lfsr[0] ? 12'hFFF : {lfsr, lfsr[7:4]};
            pins(lfsr[1], lfsr[2]);
        end
        // Frozen clock enable must hold the supply on outputs
        ce = 1'b0;
        for (int i = 0; i < 12; i++) keep[i] = on_of(i) != 0;
        p0 = ~p0;
        p1 = ~p1;
        repeat (6) @(negedge clk_sys);
        chk(son, keep);
        ce = 1'b1;
        pins(p0, p1);
        print_verdict();
    end
endmodule
